// File: mci_defines.svh
// constants for the motion command interpreter
`ifndef MCI_DEFINES_SVH
`define MCI_DEFINES_SVH
`define MCI_FRAME_BYTES   4'd9
`define MCI_INSTR_ROT_RIGHT 8'h01
`define MCI_INSTR_ROT_LEFT  8'h02
`define MCI_INSTR_SOFT_STOP 8'h03
`define MCI_INSTR_MOVE_POS  8'h04
`define MCI_INSTR_SET_PARAM 8'h05
`define MCI_INSTR_GET_PARAM 8'h06
`define MCI_TGT_ABSOLUTE  8'h00
`define MCI_TGT_OFFSET    8'h01
`define MCI_TGT_POINT     8'h02
`define MCI_PAR_TARGET    8'h00
`define MCI_PAR_ACTUAL    8'h01
`define MCI_PAR_VELOCITY  8'h02
`define MCI_ST_OK         8'h64
`define MCI_ST_BAD_CSUM   8'h01
`define MCI_ST_BAD_CMD    8'h02
`define MCI_ST_BAD_TYPE   8'h03
`define MCI_ST_BAD_VALUE  8'h04
`define MCI_REPLY_ADDR    8'h02
`define MCI_NUM_PARAMS    8
`define MCI_NUM_AXES      4
`define MCI_NUM_POINTS    21
`endif

// File: mci_pkg.sv
// types shared by the motion command interpreter
`default_nettype none
package mci_pkg;
	typedef enum logic [1:0] {
		MCI_MODE_POSITION,
		MCI_MODE_VELOCITY
	} mci_mode_t;
	typedef enum {
		MCI_S_COLLECT,
		MCI_S_EXEC,
		MCI_S_REPLY
	} mci_state_t;
endpackage
`default_nettype wire

// File: mci_axis.sv
// one axis: volatile parameter file, motion mode and move flag
`timescale 1ns/10ps
`default_nettype none
`include "mci_defines.svh"
module mci_axis
	import mci_pkg::*;
#(
	parameter int NUM_PARAMS = `MCI_NUM_PARAMS
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// commands from the interpreter
	input  wire logic        wr_i,
	input  wire logic [2:0]  wr_idx_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        stop_i,
	input  wire logic        move_i,
	input  wire logic        rot_i,
	input  wire logic [2:0]  rd_idx_i,
	// state
	output logic [31:0]      rd_data_o,
	output logic [31:0]      actual_o,
	output logic             moving_o,
	output mci_mode_t        mode_o
);
	// sram-like flops only: nothing survives power loss
	logic [31:0] param_reg [NUM_PARAMS];
	logic        moving_reg;
	mci_mode_t   mode_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NUM_PARAMS; i++) begin
				param_reg[i] <= 32'h0;
			end
			moving_reg <= 1'b0;
			mode_reg   <= MCI_MODE_POSITION;
		end else if (stop_i) begin
			// velocity mode and a zeroed target (param 0) in the same cycle
			mode_reg     <= MCI_MODE_VELOCITY;
			param_reg[0] <= 32'h0;
			moving_reg   <= 1'b0;
		end else if (wr_i) begin
			param_reg[wr_idx_i] <= wr_data_i;
			if (move_i) begin
				mode_reg   <= MCI_MODE_POSITION;
				moving_reg <= 1'b1;
			end else if (rot_i) begin
				// rotation leaves positioning: velocity mode, move dropped
				mode_reg   <= MCI_MODE_VELOCITY;
				moving_reg <= 1'b0;
			end
		end
	end

	assign rd_data_o = param_reg[rd_idx_i];
	assign actual_o  = param_reg[1];
	assign moving_o  = moving_reg;
	assign mode_o    = mode_reg;
endmodule
`default_nettype wire

// File: mci_core.sv
// motion command interpreter: frame collection, decode, execute, reply
`timescale 1ns/10ps
`default_nettype none
`include "mci_defines.svh"
module mci_core
	import mci_pkg::*;
#(
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter int         NUM_AXES    = `MCI_NUM_AXES
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// command byte stream, same clock domain
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        from_program_i,
	// stored points loaded by the point commands elsewhere
	input  wire logic [31:0] point_data_i,
	output logic [7:0]       point_idx_o,
	output logic [1:0]       point_axis_o,
	// reply stream
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	input  wire logic        tx_ready_i,
	// state
	output logic [31:0]      accu_o,
	output logic [3:0]       moving_o,
	output logic [3:0]       velocity_mode_o
);
	logic       rst_s1_reg;
	logic       rst_n_reg;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	mci_state_t  state_reg;
	logic [7:0]  frame_reg [9];
	logic [3:0]  cnt_reg;
	logic [7:0]  sum_reg;
	logic        prog_reg;
	logic [7:0]  status_reg;
	logic [31:0] reply_val_reg;
	logic [31:0] accu_reg;
	logic [7:0]  rpl_reg [9];
	logic        tx_valid_reg;
	logic [7:0]  tx_data_reg;
	logic [3:0]  moving_reg;
	logic [3:0]  vmode_reg;

	// frame fields, value most significant byte first
	wire [7:0]  f_addr  = frame_reg[0];
	wire [7:0]  f_instr = frame_reg[1];
	wire [7:0]  f_type  = frame_reg[2];
	wire [7:0]  f_motor = frame_reg[3];
	wire [31:0] f_value = {frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7]};
	wire        csum_ok = (sum_reg == frame_reg[8]);
	wire        addr_ok = (f_addr == MODULE_ADDR);
	wire [1:0]  axis    = f_motor[1:0];
	wire        axis_ok = (f_motor < 8'(NUM_AXES));

	wire is_stop = (f_instr == `MCI_INSTR_SOFT_STOP);
	wire is_rot  = (f_instr == `MCI_INSTR_ROT_RIGHT) || (f_instr == `MCI_INSTR_ROT_LEFT);
	wire is_move = (f_instr == `MCI_INSTR_MOVE_POS);
	wire is_set  = (f_instr == `MCI_INSTR_SET_PARAM);
	wire is_get  = (f_instr == `MCI_INSTR_GET_PARAM);
	wire known   = is_stop || is_rot || is_move || is_set || is_get;
	wire par_ok  = (f_type < 8'(`MCI_NUM_PARAMS));
	wire mv_type_ok = (f_type <= `MCI_TGT_POINT);
	wire pt_ok   = (f_value < 32'(`MCI_NUM_POINTS));

	logic [31:0] rd_data [NUM_AXES];
	logic [31:0] actual  [NUM_AXES];
	logic [3:0]  mov_w;
	mci_mode_t   mode_w  [NUM_AXES];

	// signed value; relative sum wraps modulo 2^32
	wire [31:0] rel_target = 32'(actual[axis] + f_value);
	wire [31:0] move_target =
		(f_type == `MCI_TGT_ABSOLUTE) ? f_value :
		(f_type == `MCI_TGT_OFFSET) ? rel_target : point_data_i;

	wire exec    = (state_reg == MCI_S_EXEC) && addr_ok;
	wire bad_cmd = !known;
	wire bad_type = (is_move && !mv_type_ok) || ((is_set || is_get) && !par_ok);
	wire bad_val  = !axis_ok ||
		(is_move && f_type == `MCI_TGT_POINT && !pt_ok);
	wire [7:0] status_w = !csum_ok ? `MCI_ST_BAD_CSUM :
		bad_cmd ? `MCI_ST_BAD_CMD : bad_type ? `MCI_ST_BAD_TYPE :
		bad_val ? `MCI_ST_BAD_VALUE : `MCI_ST_OK;
	wire do_it   = exec && (status_w == `MCI_ST_OK);
	wire [31:0] set_val = is_rot ? f_value : (is_move ? move_target : f_value);
	wire [2:0]  set_idx = is_rot ? 3'(`MCI_PAR_VELOCITY) :
		(is_move ? 3'(`MCI_PAR_TARGET) : f_type[2:0]);

	assign point_idx_o  = f_value[7:0];
	assign point_axis_o = axis;

	genvar g;
	generate
		for (g = 0; g < NUM_AXES; g++) begin : g_axis
			wire sel = do_it && (axis == 2'(g));
			mci_axis u_axis (
				.clk_i     (clk_i),
				.rst_n_i   (rst_n_reg),
				.wr_i      (sel && (is_set || is_move || is_rot)),
				.wr_idx_i  (set_idx),
				.wr_data_i (set_val),
				.stop_i    (sel && is_stop),
				.move_i    (sel && is_move),
				.rot_i     (sel && is_rot),
				.rd_idx_i  (f_type[2:0]),
				.rd_data_o (rd_data[g]),
				.actual_o  (actual[g]),
				.moving_o  (mov_w[g]),
				.mode_o    (mode_w[g])
			);
		end
	endgenerate

	wire [7:0] rpl_sum = 8'(`MCI_REPLY_ADDR + MODULE_ADDR + status_reg + f_instr +
		reply_val_reg[31:24] + reply_val_reg[23:16] + reply_val_reg[15:8] +
		reply_val_reg[7:0]);

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg     <= MCI_S_COLLECT;
			cnt_reg       <= 4'h0;
			sum_reg       <= 8'h00;
			prog_reg      <= 1'b0;
			status_reg    <= 8'h00;
			reply_val_reg <= 32'h0;
			accu_reg      <= 32'h0;
			tx_valid_reg  <= 1'b0;
			tx_data_reg   <= 8'h00;
			moving_reg    <= 4'h0;
			vmode_reg     <= 4'h0;
			for (int i = 0; i < 9; i++) begin
				frame_reg[i] <= 8'h00;
				rpl_reg[i]   <= 8'h00;
			end
		end else begin
			moving_reg <= mov_w;
			for (int i = 0; i < NUM_AXES; i++) begin
				vmode_reg[i] <= (mode_w[i] == MCI_MODE_VELOCITY);
			end
			unique case (state_reg)
				MCI_S_COLLECT: begin
					if (rx_valid_i) begin
						frame_reg[cnt_reg] <= rx_data_i;
						if (cnt_reg < 4'd8) begin
							sum_reg <= 8'(sum_reg + rx_data_i);
						end
						if (cnt_reg == 4'd0) begin
							prog_reg <= from_program_i;
						end
						if (cnt_reg == `MCI_FRAME_BYTES - 4'd1) begin
							state_reg <= MCI_S_EXEC;
							cnt_reg   <= 4'h0;
						end else begin
							cnt_reg <= cnt_reg + 4'd1;
						end
					end
				end
				MCI_S_EXEC: begin
					// move is set up in this one cycle, reply follows only for a frame to MODULE_ADDR
					status_reg    <= status_w;
					reply_val_reg <= (is_get && status_w == `MCI_ST_OK) ? rd_data[axis] : 32'h0;
					if (do_it && is_get && prog_reg) begin
						accu_reg <= rd_data[axis];
					end
					sum_reg   <= 8'h00;
					state_reg <= addr_ok ? MCI_S_REPLY : MCI_S_COLLECT;
				end
				MCI_S_REPLY: begin
					if (!tx_valid_reg) begin
						rpl_reg[0] <= `MCI_REPLY_ADDR;
						rpl_reg[1] <= MODULE_ADDR;
						rpl_reg[2] <= status_reg;
						rpl_reg[3] <= f_instr;
						rpl_reg[4] <= reply_val_reg[31:24];
						rpl_reg[5] <= reply_val_reg[23:16];
						rpl_reg[6] <= reply_val_reg[15:8];
						rpl_reg[7] <= reply_val_reg[7:0];
						rpl_reg[8] <= rpl_sum;
						tx_data_reg  <= `MCI_REPLY_ADDR;
						tx_valid_reg <= 1'b1;
						cnt_reg      <= 4'h0;
					end else if (tx_ready_i) begin
						if (cnt_reg == `MCI_FRAME_BYTES - 4'd1) begin
							tx_valid_reg <= 1'b0;
							cnt_reg      <= 4'h0;
							state_reg    <= MCI_S_COLLECT;
						end else begin
							tx_data_reg <= rpl_reg[cnt_reg + 4'd1];
							cnt_reg     <= cnt_reg + 4'd1;
						end
					end
				end
			endcase
		end
	end

	assign tx_valid_o      = tx_valid_reg;
	assign tx_data_o       = tx_data_reg;
	assign accu_o          = accu_reg;
	assign moving_o        = moving_reg;
	assign velocity_mode_o = vmode_reg;

	stop_vel_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(do_it && is_stop) |=> ##1 vmode_reg[axis])
		else $error("stop did not select velocity mode");
	host_accu_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(exec && !prog_reg) |=> $stable(accu_reg))
		else $error("host fetch changed accumulator");
	get_ok_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(do_it && is_get) |=> (status_reg == `MCI_ST_OK))
		else $error("fetch not answered ok");
	move_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(do_it && is_move) |=> ##1 moving_reg[axis])
		else $error("move did not start");
	reply_soon_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(exec) |=> ##[1:2] tx_valid_reg)
		else $error("reply not started");
	bad_sum_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(exec && !csum_ok) |=> (status_reg == `MCI_ST_BAD_CSUM))
		else $error("checksum error missed");
	prog_accu_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(do_it && is_get && prog_reg) |=> (accu_reg == reply_val_reg))
		else $error("program fetch missed accumulator");
	abort_a: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
		(do_it && (is_stop || is_rot)) |=> ##1 !moving_reg[$past(axis)])
		else $error("move not aborted");
endmodule
`default_nettype wire

// File: mci_host.sv
// host model: sends command frames and takes the reply frames
`timescale 1ns/10ps
`default_nettype none
module mci_host (
	// clock
	input  wire logic       clk_i,
	// command byte stream
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            from_program_o,
	// reply byte stream
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o
);
	logic [7:0] rep [0:8];
	int         n_rep;

	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		from_program_o = 1'b0;
		tx_ready_o = 1'b0;
	end

	// bad is added into the sum so a scenario can spoil the check byte
	task automatic send(input logic [63:0] f, input logic prog, input logic [7:0] bad);
		logic [7:0] b;
		logic [7:0] sum;
		sum = bad;
		for (int k = 0; k < 9; k++) begin
			b = (k < 8) ? f[63-8*k -: 8] : sum;
			sum = sum + b;
			@(negedge clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= b;
			from_program_o <= prog;
			@(negedge clk_i);
			rx_valid_o <= 1'b0;
			// released data must not keep showing the last byte
			rx_data_o <= ~b;
			repeat ($urandom_range(0, 2)) @(negedge clk_i);
		end
	endtask

	// random stalls on ready so the reply has to stand
	task automatic receive(input int limit);
		logic rdy;
		n_rep = 0;
		for (int c = 0; c < limit && n_rep < 9; c++) begin
			@(negedge clk_i);
			rdy = ($urandom_range(0, 3) != 0);
			tx_ready_o <= rdy;
			// valid and data are settled here and hold until the edge that takes them
			if (tx_valid_i === 1'b1 && rdy) begin
				rep[n_rep] = tx_data_i;
				n_rep++;
			end
		end
		@(negedge clk_i);
		tx_ready_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench top: command frames against the motion command interpreter
`timescale 1ns/10ps
`default_nettype none
`include "mci_defines.svh"
module tb_top;
	logic        clk_i;
	logic        resetn_i;
	logic        rx_valid_i;
	logic [7:0]  rx_data_i;
	logic        from_program_i;
	logic [31:0] point_data_i;
	logic [7:0]  point_idx_o;
	logic [1:0]  point_axis_o;
	logic        tx_valid_o;
	logic [7:0]  tx_data_o;
	logic        tx_ready_i;
	logic [31:0] accu_o;
	logic [3:0]  moving_o;
	logic [3:0]  velocity_mode_o;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [31:0] rv;
	logic [31:0] v;
	logic [31:0] act;
	logic [31:0] acc;
	logic [7:0]  op;

	// stored points are a fixed pattern so their expected value is easy to form
	function automatic logic [31:0] pt(input logic [7:0] idx, input logic [1:0] ax);
		return {6'h2a, ax, 8'h5c, 8'h00, idx};
	endfunction
	assign point_data_i = pt(point_idx_o, point_axis_o);

	mci_core u_dut (
		.clk_i          (clk_i),
		.resetn_i       (resetn_i),
		.rx_valid_i     (rx_valid_i),
		.rx_data_i      (rx_data_i),
		.from_program_i (from_program_i),
		.point_data_i   (point_data_i),
		.point_idx_o    (point_idx_o),
		.point_axis_o   (point_axis_o),
		.tx_valid_o     (tx_valid_o),
		.tx_data_o      (tx_data_o),
		.tx_ready_i     (tx_ready_i),
		.accu_o         (accu_o),
		.moving_o       (moving_o),
		.velocity_mode_o(velocity_mode_o)
	);
	mci_host u_host (
		.clk_i         (clk_i),
		.rx_valid_o    (rx_valid_i),
		.rx_data_o     (rx_data_i),
		.from_program_o(from_program_i),
		.tx_valid_i    (tx_valid_o),
		.tx_data_i     (tx_data_o),
		.tx_ready_o    (tx_ready_i)
	);

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// the run takes a few thousand cycles; far beyond that means a hang
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a frame to another address must stay unanswered
	task automatic cmd(input logic [7:0] adr, ins, typ, mot, input logic [31:0] val,
		input logic prog, input logic [7:0] bad, input logic [7:0] st);
		logic [7:0] sum;
		u_host.send({adr, ins, typ, mot, val}, prog, bad);
		u_host.receive(adr == 8'h01 ? 300 : 40);
		if (adr != 8'h01) begin
			check(u_host.n_rep, 0);
		end else begin
			sum = 8'h00;
			for (int k = 0; k < 8; k++) sum = sum + u_host.rep[k];
			check(u_host.n_rep, 9);
			check({u_host.rep[0], u_host.rep[1], u_host.rep[2], u_host.rep[3]},
				{8'h02, 8'h01, st, ins});
			check(u_host.rep[8], sum);
			rv = {u_host.rep[4], u_host.rep[5], u_host.rep[6], u_host.rep[7]};
		end
	endtask

	task automatic ok(input logic [7:0] ins, typ, mot, input logic [31:0] val, input logic prog);
		cmd(8'h01, ins, typ, mot, val, prog, 8'h00, `MCI_ST_OK);
	endtask

	task automatic refuse(input logic [7:0] ins, typ, mot, input logic [31:0] val,
		input logic [7:0] st);
		cmd(8'h01, ins, typ, mot, val, 1'b0, 8'h00, st);
	endtask

	initial begin
		resetn_i = 1'b0;
		void'($urandom(48020));
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		for (int n = 0; n < 8; n++) begin
			v = $urandom;
			op = 8'($urandom_range(3, 7));
			acc = accu_o;
			ok(`MCI_INSTR_SET_PARAM, op, 8'(n % 4), v, 1'b0);
			ok(`MCI_INSTR_GET_PARAM, op, 8'(n % 4), 32'h0, 1'b0);
			check(rv, v);
			check(accu_o, acc);
			ok(`MCI_INSTR_GET_PARAM, op, 8'(n % 4), 32'h0, 1'b1);
			check(accu_o, v);
			check(rv, v);
		end
		$display("test param done");
		for (int a = 0; a < 4; a++) begin
			v = (a == 0) ? 32'h80000000 : (a == 1) ? 32'h7fffffff : $urandom;
			ok(`MCI_INSTR_MOVE_POS, `MCI_TGT_ABSOLUTE, 8'(a), v, 1'b0);
			check({moving_o[a], velocity_mode_o[a]}, 2'b10);
			ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_TARGET, 8'(a), 32'h0, 1'b0);
			check(rv, v);
			// actual position and offset both kept to 30 signed bits
			v = $urandom;
			v = {{2{v[29]}}, v[29:0]};
			ok(`MCI_INSTR_SET_PARAM, `MCI_PAR_ACTUAL, 8'(a), v, 1'b0);
			ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_ACTUAL, 8'(a), 32'h0, 1'b0);
			act = rv;
			check(act, v);
			v = $urandom;
			v = {{2{v[29]}}, v[29:0]};
			ok(`MCI_INSTR_MOVE_POS, `MCI_TGT_OFFSET, 8'(a), v, 1'b0);
			ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_TARGET, 8'(a), 32'h0, 1'b0);
			check(rv, act + v);
			v = 32'($urandom_range(0, 20));
			ok(`MCI_INSTR_MOVE_POS, `MCI_TGT_POINT, 8'(a), v, 1'b0);
			ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_TARGET, 8'(a), 32'h0, 1'b0);
			check(rv, pt(v[7:0], a[1:0]));
			op = (a < 2) ? `MCI_INSTR_SOFT_STOP : 8'(a - 1);
			acc = (a < 2) ? 32'h0 : $urandom;
			ok(op, 8'h00, 8'(a), acc, 1'b0);
			check({moving_o[a], velocity_mode_o[a]}, 2'b01);
			ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_TARGET, 8'(a), 32'h0, 1'b0);
			check(rv, (a < 2) ? 32'h0 : pt(v[7:0], a[1:0]));
			ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_VELOCITY, 8'(a), 32'h0, 1'b0);
			check(rv, acc);
		end
		$display("test motion done");
		ok(`MCI_INSTR_GET_PARAM, 8'h03, 8'h00, 32'h0, 1'b0);
		act = rv;
		cmd(8'h01, `MCI_INSTR_SET_PARAM, 8'h03, 8'h00, $urandom, 1'b0, 8'h01,
			`MCI_ST_BAD_CSUM);
		cmd(8'h01, 8'h07, 8'h00, 8'h00, 32'h0, 1'b0, 8'h00, `MCI_ST_BAD_CMD);
		cmd(8'h05, `MCI_INSTR_SET_PARAM, 8'h03, 8'h00, $urandom, 1'b0, 8'h00, 8'h00);
		refuse(`MCI_INSTR_SET_PARAM, 8'h08, 8'h00, $urandom, `MCI_ST_BAD_TYPE);
		refuse(`MCI_INSTR_SET_PARAM, 8'h03, 8'h04, $urandom, `MCI_ST_BAD_VALUE);
		ok(`MCI_INSTR_GET_PARAM, 8'h03, 8'h00, 32'h0, 1'b0);
		check(rv, act);
		refuse(`MCI_INSTR_MOVE_POS, 8'h03, 8'h00, 32'h0, `MCI_ST_BAD_TYPE);
		refuse(`MCI_INSTR_MOVE_POS, `MCI_TGT_POINT, 8'h00, 32'd21,
			`MCI_ST_BAD_VALUE);
		ok(`MCI_INSTR_GET_PARAM, `MCI_PAR_TARGET, 8'h00, 32'h0, 1'b0);
		check(rv, 32'h0);
		$display("test refusal done");
		stop_test();
	end
endmodule
`default_nettype wire
